// ---- hw/drc_refresh_cfg.sv ----
// Refresh sequencing and timing configuration of the external memory interface.
// Assumes the bus controller reports bus activity and consumes the decoded timings.
// Behaviour
// - Memory word address field picks synchronous DRAM organisation; resets to 00.
// - Refresh enable 0 means no refresh at all; resets to 0. The area-2 refresh enable still requests refresh here.
// - Refresh pacing timer is also readable and writable as an interval timer.
// - Enabled with mode 0: CBR refresh at each timer compare match.
// - Refresh request during a bus cycle terminates that cycle first.
// - Enabled with mode 1: wait for bus idle, then enter self-refresh.
// - Refresh requests during self-refresh are discarded.
// - EDO bit: rising-edge sampling and half-cycle late RAS release.
// - EDO only touches area-3 DRAM; software keeps it 0 otherwise.
// - Area-2 DRAM data bus is fixed at 16 bits.
// - Area-2 control word clears only on power-on reset.
// - Precharge 1 to 4 cycles, 2 to 11 after self-refresh.
// - RAS-to-CAS delay 1 to 4 cycles; resets to 00.
// - Refresh RAS width 2 to 5 cycles.
// - Burst bit: 0 single access, 1 page mode bursts.
// - Column address width 8 to 11 bits; resets to 00.
// - Area-2 refresh enable and mode; modes valid only when enabled.
// - Card timing word clears only on power-on; upper byte reads 0.
// - Areas 5 and 6 strobe assert delay 0.5 to 3.5 cycles.
// - Areas 5 and 6 address hold after strobe 0.5 to 3.5 cycles.
// - Strobe pulse width comes from the wait-state setting.
// - Memory control word clears only on power-on reset.
`timescale 1ns/10ps
module drc_refresh_cfg
    import drc_pkg::*;
(
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst_b,
    // Manual reset, clears sequencing only
    input wire logic manualRst_b,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Bus controller status
    input wire logic extBusActive,
    input wire logic area3Dram,
    input wire logic [3:0] waitStates,
    // Refresh control
    output logic busTerminate,
    output logic cbrRefresh,
    output logic selfRefresh,
    // Decoded timings
    output logic [1:0] sdramOrg,
    output logic [3:0] prechargeCycles,
    output logic [3:0] prechargeSelfCycles,
    output logic [3:0] rasCasCycles,
    output logic [3:0] refreshRasCycles,
    output logic [3:0] columnBits,
    output logic burstEnable,
    output logic edoRiseSample,
    output logic rasHalfDelay,
    output logic area2Width16,
    output logic [2:0] area5AssertHalf,
    output logic [2:0] area6AssertHalf,
    output logic [2:0] area5HoldHalf,
    output logic [2:0] area6HoldHalf,
    output logic [3:0] strobeWidth
);

    logic [15:0] memCtrl_reg;
    logic [15:0] dram2_reg;
    logic [15:0] card_reg;
    logic [2:0] tmrSel_reg;
    logic [TMR_W-1:0] tmrCmp_reg;
    logic tmrFlag_reg;
    logic cbrPend_reg;
    logic [3:0] cnt_reg;
    drc_state_t state_reg;
    logic [TMR_W-1:0] tmrCount;
    logic tmrMatch;
    logic wrStb;
    logic cbrEn;
    logic selfEn;
    logic [15:0] rdWord;

    assign wrStb = cyc_i && stb_i && we_i && !ack_o;
    // Either word may request refresh; mode bits only count when enabled
    assign cbrEn = (memCtrl_reg[BIT_REF_EN] && !memCtrl_reg[BIT_REF_MODE])
                   || (dram2_reg[BIT_REF_EN] && !dram2_reg[BIT_REF_MODE]);
    assign selfEn = (memCtrl_reg[BIT_REF_EN] && memCtrl_reg[BIT_REF_MODE])
                    || (dram2_reg[BIT_REF_EN] && dram2_reg[BIT_REF_MODE]);

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration words; only power-on reset clears them
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            memCtrl_reg <= MEM_CTRL_RST;
            dram2_reg <= DRAM2_RST;
            card_reg <= CARD_RST;
            tmrSel_reg <= TMR_SEL_RST;
            tmrCmp_reg <= TMR_CMP_RST;
        end else if (wrStb) begin
            case (adr_i)
                OFF_MEM_CTRL: memCtrl_reg <= merge_word(memCtrl_reg, dat_i, sel_i, MEM_CTRL_WMASK);
                OFF_DRAM2: dram2_reg <= merge_word(dram2_reg, dat_i, sel_i, DRAM2_WMASK);
                OFF_CARD: card_reg <= merge_word(card_reg, dat_i, sel_i, CARD_WMASK);
                OFF_TMR_CTRL: begin
                    if (sel_i[0]) begin
                        tmrSel_reg <= dat_i[BIT_TMR_SEL +: 3];
                    end
                end
                OFF_TMR_CMP: begin
                    if (sel_i[0]) begin
                        tmrCmp_reg <= dat_i[TMR_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interval timer; its count register is also software writable
    drc_interval_timer #(
        .CNT_W(TMR_W)
    ) u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .clkSel(tmrSel_reg),
        .cmpVal(tmrCmp_reg),
        .cntWrite(wrStb && adr_i == OFF_TMR_CNT && sel_i[0]),
        .cntWdata(dat_i[TMR_W-1:0]),
        .count(tmrCount),
        .match(tmrMatch)
    );

    // Compare flag: writing 0 clears, a match in the same cycle wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tmrFlag_reg <= 1'b0;
        end else if (tmrMatch) begin
            tmrFlag_reg <= 1'b1;
        end else if (wrStb && adr_i == OFF_TMR_CTRL && sel_i[0] && !dat_i[BIT_TMR_FLAG]) begin
            tmrFlag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pending CBR request; discarded while memory sits in self-refresh
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cbrPend_reg <= 1'b0;
        end else if (!manualRst_b || !cbrEn) begin
            cbrPend_reg <= 1'b0;
        end else if (tmrMatch && !selfRefresh && !selfEn) begin
            cbrPend_reg <= 1'b1;
        end else if (state_reg == ST_IDLE && !extBusActive) begin
            cbrPend_reg <= 1'b0;
        end else if (state_reg == ST_ABORT && !extBusActive) begin
            cbrPend_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Refresh sequencer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            busTerminate <= 1'b0;
            cbrRefresh <= 1'b0;
            selfRefresh <= 1'b0;
        end else if (!manualRst_b) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            busTerminate <= 1'b0;
            cbrRefresh <= 1'b0;
            selfRefresh <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (selfEn) begin
                        if (!extBusActive) begin
                            state_reg <= ST_SELF;
                            selfRefresh <= 1'b1;
                        end
                    end else if (cbrPend_reg && cbrEn) begin
                        if (extBusActive) begin
                            state_reg <= ST_ABORT;
                            busTerminate <= 1'b1;
                        end else begin
                            state_reg <= ST_CBR;
                            cbrRefresh <= 1'b1;
                            cnt_reg <= ras_width_cycles(dram2_reg[BIT_TRAS +: 2]) - 4'h1;
                        end
                    end
                end
                ST_ABORT: begin
                    if (!extBusActive) begin
                        state_reg <= ST_CBR;
                        busTerminate <= 1'b0;
                        cbrRefresh <= 1'b1;
                        cnt_reg <= ras_width_cycles(dram2_reg[BIT_TRAS +: 2]) - 4'h1;
                    end
                end
                ST_CBR: begin
                    if (cnt_reg == 4'h0) begin
                        state_reg <= ST_PRECH;
                        cbrRefresh <= 1'b0;
                        cnt_reg <= precharge_cycles(dram2_reg[BIT_TPC +: 2]) - 4'h1;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                ST_PRECH: begin
                    if (cnt_reg == 4'h0) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                ST_SELF: begin
                    if (!selfEn) begin
                        state_reg <= ST_SELF_EXIT;
                        selfRefresh <= 1'b0;
                        cnt_reg <= precharge_self_cycles(dram2_reg[BIT_TPC +: 2]) - 4'h1;
                    end
                end
                ST_SELF_EXIT: begin
                    if (cnt_reg == 4'h0) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded timings, frozen while a bus cycle runs so a write lands on the next one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sdramOrg <= 2'h0;
            prechargeCycles <= 4'h1;
            prechargeSelfCycles <= 4'h2;
            rasCasCycles <= 4'h1;
            refreshRasCycles <= 4'h2;
            columnBits <= 4'h8;
            burstEnable <= 1'b0;
            edoRiseSample <= 1'b0;
            rasHalfDelay <= 1'b0;
            area2Width16 <= 1'b1;
            area5AssertHalf <= 3'h1;
            area6AssertHalf <= 3'h1;
            area5HoldHalf <= 3'h1;
            area6HoldHalf <= 3'h1;
            strobeWidth <= 4'h0;
        end else if (!extBusActive) begin
            sdramOrg <= memCtrl_reg[BIT_AMX +: 2];
            prechargeCycles <= precharge_cycles(dram2_reg[BIT_TPC +: 2]);
            prechargeSelfCycles <= precharge_self_cycles(dram2_reg[BIT_TPC +: 2]);
            rasCasCycles <= {2'h0, dram2_reg[BIT_RCD +: 2]} + 4'h1;
            refreshRasCycles <= ras_width_cycles(dram2_reg[BIT_TRAS +: 2]);
            columnBits <= {2'h2, dram2_reg[BIT_AMX +: 2]};
            burstEnable <= dram2_reg[BIT_BURST];
            // Only area-3 DRAM sees the EDO timing
            edoRiseSample <= memCtrl_reg[BIT_EDO] && area3Dram;
            rasHalfDelay <= memCtrl_reg[BIT_EDO] && area3Dram;
            area2Width16 <= 1'b1;
            area5AssertHalf <= half_cycles(card_reg[BIT_A5_ASSERT +: 2]);
            area6AssertHalf <= half_cycles(card_reg[BIT_A6_ASSERT +: 2]);
            area5HoldHalf <= half_cycles(card_reg[BIT_A5_HOLD +: 2]);
            area6HoldHalf <= half_cycles(card_reg[BIT_A6_HOLD +: 2]);
            strobeWidth <= waitStates;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone answer: one wait state, unmapped reads return zero
    always_comb begin
        rdWord = 16'h0000;
        case (adr_i)
            OFF_MEM_CTRL: rdWord = memCtrl_reg;
            OFF_DRAM2: rdWord = dram2_reg;
            OFF_CARD: rdWord = card_reg;
            OFF_TMR_CTRL: rdWord = {12'h000, tmrFlag_reg, tmrSel_reg};
            OFF_TMR_CMP: rdWord = {{(16-TMR_W){1'b0}}, tmrCmp_reg};
            OFF_TMR_CNT: rdWord = {{(16-TMR_W){1'b0}}, tmrCount};
            OFF_STATUS: rdWord = {10'h000, state_reg, selfRefresh, cbrPend_reg, busTerminate};
            default: rdWord = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            dat_o <= {16'h0000, rdWord};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [3:0] rasLen;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rasLen <= 4'h0;
        end else if (cbrRefresh) begin
            rasLen <= rasLen + 4'h1;
        end else begin
            rasLen <= 4'h0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_card_upper_zero: assert property (ack_o && !we_i && adr_i == OFF_CARD
        |-> dat_o[15:8] == 8'h00)
        else $error("card timing upper byte not zero");
    a_self_no_cbr: assert property (selfRefresh |-> !cbrRefresh && !$rose(cbrPend_reg))
        else $error("refresh request during self-refresh");
    a_abort_busy: assert property (state_reg == ST_IDLE && !selfEn && cbrPend_reg && extBusActive
                                   && cbrEn && manualRst_b |=> busTerminate)
        else $error("busy bus not terminated for refresh");
    a_self_bus_idle: assert property ($rose(selfRefresh) |-> $past(!extBusActive))
        else $error("self-refresh entered during bus cycle");
    a_ras_width: assert property ($fell(cbrRefresh) && $past(manualRst_b)
        |-> rasLen == refreshRasCycles)
        else $error("refresh RAS width wrong");
    a_no_refresh_off: assert property (state_reg == ST_IDLE && !cbrEn && !selfEn
        |=> state_reg == ST_IDLE)
        else $error("refresh while disabled");
    a_rcd_decode: assert property (!extBusActive
        |=> rasCasCycles == {2'h0, $past(dram2_reg[13:12])} + 4'h1)
        else $error("RAS-CAS delay decode wrong");
    a_col_decode: assert property (!extBusActive
        |=> columnBits == {2'h2, $past(dram2_reg[4:3])})
        else $error("column width decode wrong");
    a_edo_area3: assert property ($rose(edoRiseSample) |-> $past(area3Dram))
        else $error("EDO timing outside area-3 DRAM");
    a_hold_frozen: assert property (extBusActive
        |=> $stable(area5AssertHalf) && $stable(prechargeCycles))
        else $error("timing changed inside a bus cycle");

    c_cbr: cover property ($rose(cbrRefresh));
    c_abort: cover property ($rose(busTerminate));
    c_self: cover property ($rose(selfRefresh));
    c_write: cover property (ack_o && we_i);

endmodule : drc_refresh_cfg

// ---- hw/drc_pkg.sv ----
// Constants, field layout and decode helpers of the DRAM refresh and card timing block.
// Assumes a 32-bit classic Wishbone register bus with 16-bit registers in the low lanes.
package drc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam int ADR_W = 5;
    localparam logic [4:0] OFF_MEM_CTRL = 5'h00;
    localparam logic [4:0] OFF_DRAM2 = 5'h04;
    localparam logic [4:0] OFF_CARD = 5'h08;
    localparam logic [4:0] OFF_TMR_CTRL = 5'h0C;
    localparam logic [4:0] OFF_TMR_CMP = 5'h10;
    localparam logic [4:0] OFF_TMR_CNT = 5'h14;
    localparam logic [4:0] OFF_STATUS = 5'h18;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions of the memory and area-2 control words
    localparam int BIT_TPC = 14;
    localparam int BIT_RCD = 12;
    localparam int BIT_TRAS = 8;
    localparam int BIT_BURST = 6;
    localparam int BIT_AMX = 3;
    localparam int BIT_REF_EN = 2;
    localparam int BIT_REF_MODE = 1;
    localparam int BIT_EDO = 0;
    // Card strobe timing fields
    localparam int BIT_A5_ASSERT = 6;
    localparam int BIT_A6_ASSERT = 4;
    localparam int BIT_A5_HOLD = 2;
    localparam int BIT_A6_HOLD = 0;
    // Timer control fields
    localparam int BIT_TMR_SEL = 0;
    localparam int BIT_TMR_FLAG = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // Writable masks and reset values
    localparam logic [15:0] MEM_CTRL_WMASK = 16'hFF7F;
    localparam logic [15:0] DRAM2_WMASK = 16'hF35E;
    localparam logic [15:0] CARD_WMASK = 16'h00FF;
    localparam logic [15:0] MEM_CTRL_RST = 16'h0000;
    localparam logic [15:0] DRAM2_RST = 16'h0000;
    localparam logic [15:0] CARD_RST = 16'h0000;
    localparam logic [2:0] TMR_SEL_RST = 3'h0;
    localparam int TMR_W = 8;
    localparam logic [7:0] TMR_CMP_RST = 8'h00;
    localparam logic [12:0] PRESCALE_MAX = 13'h1000;

    ////////////////////////////////////////////////////////////////////////////////
    // Refresh sequencer states, Gray along idle-abort-refresh-precharge
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ABORT = 3'h1,
        ST_CBR = 3'h3,
        ST_PRECH = 3'h2,
        ST_SELF = 3'h6,
        ST_SELF_EXIT = 3'h7
    } drc_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helpers
    function automatic logic [3:0] precharge_cycles(input logic [1:0] code);
        precharge_cycles = {2'h0, code} + 4'h1;
    endfunction : precharge_cycles

    function automatic logic [3:0] precharge_self_cycles(input logic [1:0] code);
        precharge_self_cycles = {2'h0, code} * 4'h3 + 4'h2;
    endfunction : precharge_self_cycles

    function automatic logic [3:0] ras_width_cycles(input logic [1:0] code);
        ras_width_cycles = {2'h0, code} + 4'h2;
    endfunction : ras_width_cycles

    // Strobe delay in half bus clocks: 1, 3, 5, 7
    function automatic logic [2:0] half_cycles(input logic [1:0] code);
        half_cycles = {code, 1'b1};
    endfunction : half_cycles

    function automatic logic [12:0] prescale_div(input logic [2:0] sel);
        case (sel)
            3'h1: prescale_div = 13'h0004;
            3'h2: prescale_div = 13'h0010;
            3'h3: prescale_div = 13'h0040;
            3'h4: prescale_div = 13'h0100;
            3'h5: prescale_div = 13'h0400;
            3'h6: prescale_div = 13'h0800;
            3'h7: prescale_div = 13'h1000;
            default: prescale_div = 13'h0000;
        endcase
    endfunction : prescale_div

    function automatic logic [15:0] merge_word(input logic [15:0] old, input logic [31:0] wdat,
                                               input logic [3:0] sel, input logic [15:0] mask);
        logic [15:0] lanes;
        lanes = {{8{sel[1]}}, {8{sel[0]}}} & mask;
        merge_word = (old & ~lanes) | (wdat[15:0] & lanes);
    endfunction : merge_word

endpackage : drc_pkg

// ---- hw/drc_interval_timer.sv ----
// Prescaled interval timer that paces refresh requests and serves software as a timer.
// Assumes one clock; the compare match is a one-cycle pulse.
`timescale 1ns/10ps
module drc_interval_timer
    import drc_pkg::*;
#(
    parameter int CNT_W = TMR_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Setup
    input wire logic [2:0] clkSel,
    input wire logic [CNT_W-1:0] cmpVal,
    input wire logic cntWrite,
    input wire logic [CNT_W-1:0] cntWdata,
    // Result
    output logic [CNT_W-1:0] count,
    output logic match
);
    generate
        if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
            $error("drc_interval_timer: CNT_W must be 2 to 16");
        end
    endgenerate

    logic [11:0] preReg;
    logic tick;
    logic [12:0] div;

    assign div = prescale_div(clkSel);
    assign tick = (clkSel != 3'h0) && ({1'b0, preReg} == div - 13'h0001);

    ////////////////////////////////////////////////////////////////////////////////
    // Prescaler enable pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            preReg <= 12'h000;
        end else if (tick || clkSel == 3'h0) begin
            preReg <= 12'h000;
        end else begin
            preReg <= preReg + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Up counter, cleared on compare match
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
            match <= 1'b0;
        end else begin
            match <= 1'b0;
            if (cntWrite) begin
                count <= cntWdata;
            end else if (tick) begin
                if (count == cmpVal) begin
                    count <= '0;
                    match <= 1'b1;
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end

endmodule : drc_interval_timer

// ---- dv/drc_bus_model.sv ----
// Far-side model: bus controller activity and area wiring.
// Assumes one clock; ends its cycle when the block asks to terminate.
`timescale 1ns/10ps
module drc_bus_model (
    // Clock and stimulus
    input wire logic clk,
    input wire logic rst_b,
    input wire logic busyReq,
    input wire logic area3In,
    // Block side
    input wire logic busTerminate,
    output logic extBusActive,
    output logic area3Dram,
    output logic [3:0] waitStates
);
    assign area3Dram = area3In;
    assign waitStates = 4'h5;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            extBusActive <= 1'b0;
        end else begin
            extBusActive <= busyReq & ~busTerminate;
        end
    end
endmodule : drc_bus_model

// ---- dv/tb.sv ----
// Self-checking bench of the refresh and card timing block.
// Assumes the far-side model drives bus activity.
`timescale 1ns/10ps
module tb;
    import drc_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, manualRst_b = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic we_i = 1'b0, busyReq = 1'b0, sawCbr = 1'b0, area3In = 1'b1;
    logic [ADR_W-1:0] adr_i = '0;
    logic [3:0] sel_i = 4'h3, waitStates;
    logic [31:0] dat_i = '0, dat_o;
    logic ack_o, extBusActive, area3Dram, busTerminate, cbrRefresh, selfRefresh;
    logic burstEnable, edoRiseSample, rasHalfDelay, area2Width16;
    logic [1:0] sdramOrg;
    logic [3:0] prechargeCycles, prechargeSelfCycles, rasCasCycles, refreshRasCycles;
    logic [3:0] columnBits, strobeWidth;
    logic [2:0] area5AssertHalf, area6AssertHalf, area5HoldHalf, area6HoldHalf;
    logic [15:0] r;
    int miscompares = 0, nChecks = 0, tick = 0, n;
    wire [15:0] tim = {prechargeCycles, rasCasCycles, refreshRasCycles, columnBits};
    wire [15:0] half = {1'b0, area5AssertHalf, 1'b0, area6AssertHalf, 1'b0, area5HoldHalf,
        1'b0, area6HoldHalf};
    wire [15:0] misc = {burstEnable, edoRiseSample, rasHalfDelay, area2Width16, strobeWidth,
        2'b00, sdramOrg, prechargeSelfCycles};
    always #12.5 clk = ~clk;
    drc_refresh_cfg dut (.clk, .rst_b, .manualRst_b, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .extBusActive, .area3Dram, .waitStates, .busTerminate,
        .cbrRefresh, .selfRefresh, .sdramOrg, .prechargeCycles, .prechargeSelfCycles,
        .rasCasCycles, .refreshRasCycles, .columnBits, .burstEnable, .edoRiseSample,
        .rasHalfDelay, .area2Width16, .area5AssertHalf, .area6AssertHalf, .area5HoldHalf,
        .area6HoldHalf, .strobeWidth);
    drc_bus_model partner (.clk, .rst_b, .busyReq, .busTerminate, .extBusActive, .area3Dram,
        .waitStates, .area3In);
    task automatic end_sim;
        $display("checks %0d mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Classic cycle; ack and read data taken at the edge that samples ack high
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {16'h0000, d};
        do @(posedge clk); while (ack_o !== 1'b1);
        r = dat_o[15:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : acc
    task automatic rc(input logic [4:0] a, input logic [15:0] exp);
        acc(1'b0, a, 16'h0000);
        chk(r, exp);
    endtask : rc
    task automatic waitHi(ref logic s);
        n = 0;
        while (s !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
    endtask : waitHi
    always @(posedge clk) begin
        tick <= tick + 1;
        if (cbrRefresh === 1'b1) sawCbr <= 1'b1;
        if (tick == 5000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rc(5'h00, 16'h0000);
        rc(5'h04, 16'h0000);
        rc(5'h08, 16'h0000);
        rc(5'h1C, 16'h0000);
        chk(tim, 16'h1128);
        chk(half, 16'h1111);
        chk(misc, 16'h1502);
        acc(1'b1, 5'h08, 16'hFFE4);
        rc(5'h08, 16'h00E4);
        chk(half, 16'h7531);
        busyReq <= 1'b1;
        acc(1'b1, 5'h04, 16'hFFFF);
        rc(5'h04, 16'hF35E);
        chk(tim, 16'h1128);
        chk({15'h0000, selfRefresh}, 16'h0000);
        busyReq <= 1'b0;
        repeat (4) @(posedge clk);
        chk({15'h0000, selfRefresh}, 16'h0001);
        chk(tim, 16'h445B);
        chk(misc, 16'h950B);
        acc(1'b1, 5'h04, 16'h0000);
        repeat (30) @(posedge clk);
        manualRst_b <= 1'b0;
        @(posedge clk);
        manualRst_b <= 1'b1;
        rc(5'h08, 16'h00E4);
        acc(1'b1, 5'h0C, 16'h0001);
        acc(1'b1, 5'h10, 16'h0003);
        repeat (60) @(posedge clk);
        chk({15'h0000, sawCbr}, 16'h0000);
        rc(5'h0C, 16'h0009);
        rc(5'h10, 16'h0003);
        busyReq <= 1'b1;
        acc(1'b1, 5'h00, 16'h001D);
        waitHi(busTerminate);
        chk({15'h0000, busTerminate}, 16'h0001);
        @(posedge clk);
        busyReq <= 1'b0;
        waitHi(cbrRefresh);
        n = 0;
        while (cbrRefresh === 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk(n[15:0], 16'h0002);
        chk(misc, 16'h7532);
        @(posedge clk);
        area3In <= 1'b0;
        repeat (3) @(posedge clk);
        chk(misc, 16'h1532);
        end_sim();
    end
endmodule : tb
